// ---- logic/pin_sync.sv ----
/*
 * Two-flop synchroniser for a group of level inputs.
 * Assumes the inputs are asynchronous levels; the output is one clock domain.
 */
`timescale 1ns/1ps
`default_nettype none

module pin_sync #(
   parameter int WIDTH = 1
) (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic [WIDTH-1:0] asyncIn,
   output logic [WIDTH-1:0] syncOut
);

   logic [WIDTH-1:0] stage1;

   // first stage feeds only the second stage
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         stage1 <= '0;
         syncOut <= '0;
      end else begin
         stage1 <= asyncIn;
         syncOut <= stage1;
      end
   end

endmodule

`default_nettype wire

// ---- logic/power_ctrl.sv ----
/*
 * Idle and economy power controller: machine-cycle divider, idle entry and
 * wake, reset sequencing from pin, power-on/fail and watchdog, APB registers.
 * Assumes the core pulses instrDone at the end of each instruction, and the
 * interrupt controller and watchdog run on clk_sys and give same-domain levels.
 */
// Overview of operation
// - writing 1 to the idle bit idles after the current instruction ends
// - idle stops the core clock, peripherals keep ticking, core state frozen
// - in idle address-latch and program-read strobes high, ports held
// - enabled interrupt in idle clears idle bit and starts the service routine
// - reset ends idle; pin must be high two machine cycles (8 clocks)
// - power-on/fail and watchdog resets also end idle
// - reset from idle loads PC zero, resets registers, runs at once
// - on reset exit from idle the following instruction is discarded
// - watchdog timeout wakes idle; reset follows 512 clocks unless cleared
// - machine cycle is 4 clocks by default, economy gives 4, 64 or 1024
// - in idle peripherals tick at clock/4, in economy at the core rate
// - divider field bits 7:6: 00 reserved, 01 /4, 10 /64, 11 /1024
// - a new rate takes effect one instruction cycle after its write
`timescale 1ns/1ps
`default_nettype none

module power_ctrl
   import power_ctrl_pkg::*;
(
   input wire logic clk_sys,
   input wire logic rst,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // core and peripheral handshakes
   input wire logic instrDone,
   input wire logic intRequest,
   input wire logic wdogTimeout,
   input wire logic wdogClear,
   input wire logic wdogResetEnable,
   // asynchronous pins
   input wire logic resetPin,
   input wire logic powerFail,
   // outputs
   output logic coreTick,
   output logic periphTick,
   output logic strobeForceHigh,
   output logic portHold,
   output logic serviceStart,
   output logic coreReset,
   output logic discardNext,
   output logic irq
);
   import power_ctrl_pkg::*;

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   typedef struct packed {
      power_state_t mode;
      logic idleBit;
      logic [1:0] divCode;
      logic [1:0] divPending;
      logic pendValid;
      logic [DIV_CNT_W-1:0] divCnt;
      logic [1:0] pinSamples;
      logic [1:0] holdCnt;
      logic fromIdle;
      logic wdogArmed;
      logic [WDOG_CNT_W-1:0] wdogCnt;
      logic [IRQ_WIDTH-1:0] status;
      logic [IRQ_WIDTH-1:0] mask;
      logic [31:0] rdata;
      logic serviceStart;
      logic discardNext;
   } ctrl_state_t;

   ctrl_state_t cur, next_cur;
   logic [1:0] pinsSync;
   logic resetSync, porSync;
   logic tick;
   logic [DIV_CNT_W-1:0] divLast;
   logic wrAcc, rdSetup, mapped;
   logic [IRQ_WIDTH-1:0] events;
   logic [1:0] wrDiv;
   logic resetCause;

   // ----------------------------------------------------------------
   // pin synchronisers
   // ----------------------------------------------------------------
   pin_sync #(
      .WIDTH(2)
   ) u_pin_sync (
      .clk_sys(clk_sys),
      .rst(rst),
      .asyncIn({powerFail, resetPin}),
      .syncOut(pinsSync)
   );

   assign resetSync = pinsSync[0];
   assign porSync = pinsSync[1];

   // ----------------------------------------------------------------
   // decode helpers
   // ----------------------------------------------------------------
   // machine-cycle length from the active code; idle and reset run at /4
   always_comb begin
      divLast = DIV_CNT_W'(CLOCKS_RATE_4 - 1);
      if (cur.mode == ST_RUN) begin
         case (cur.divCode)
            DIV_BY_64: divLast = DIV_CNT_W'(CLOCKS_RATE_64 - 1);
            DIV_BY_1024: divLast = DIV_CNT_W'(CLOCKS_RATE_1024 - 1);
            default: divLast = DIV_CNT_W'(CLOCKS_RATE_4 - 1);
         endcase
      end
   end

   // compare with >= so a switch to a shorter cycle ends a long count at once
   assign tick = (cur.divCnt >= divLast);
   assign mapped = (paddr == OFS_POWER_CONTROL) || (paddr == OFS_POWER_MODE)
      || (paddr == OFS_IRQ_STATUS) || (paddr == OFS_IRQ_MASK) || (paddr == OFS_STATE);
   assign wrAcc = psel && penable && pwrite && mapped;
   assign rdSetup = psel && !penable;
   assign wrDiv = {pwdata[CLOCK_DIV_HIGH_POS], pwdata[CLOCK_DIV_LOW_POS]};
   // any reset source: qualified pin, power-on/fail pin or watchdog countdown
   assign resetCause = (cur.pinSamples == 2'(EXT_RESET_MIN_MCYCLES - 1) && resetSync && tick)
      || porSync
      || (cur.wdogArmed && cur.wdogCnt == WDOG_CNT_W'(WDOG_RESET_CLOCKS - 1));

   // ----------------------------------------------------------------
   // next-state logic
   // ----------------------------------------------------------------
   always_comb begin
      next_cur = cur;
      events = '0;
      next_cur.serviceStart = 1'b0;
      next_cur.discardNext = 1'b0;

      // machine-cycle divider, always running on the oscillator
      next_cur.divCnt = tick ? '0 : cur.divCnt + DIV_CNT_W'(1);

      // a pin pulse shorter than one machine cycle is never taken as a reset
      // pin sampled once per machine cycle, two highs in a row needed
      if (tick) begin
         if (!resetSync)
            next_cur.pinSamples = '0;
         else if (cur.pinSamples != 2'(EXT_RESET_MIN_MCYCLES - 1))
            next_cur.pinSamples = cur.pinSamples + 2'h1;
      end

      // a second timeout while armed does not restart the countdown
      // watchdog reset countdown after a timeout, aborted by a clear
      if (wdogClear) begin
         next_cur.wdogArmed = 1'b0;
         next_cur.wdogCnt = '0;
      end else if (wdogTimeout && wdogResetEnable && !cur.wdogArmed) begin
         next_cur.wdogArmed = 1'b1;
         next_cur.wdogCnt = '0;
      end else if (cur.wdogArmed) begin
         next_cur.wdogCnt = cur.wdogCnt + WDOG_CNT_W'(1);
      end

      // register writes; unmapped addresses never reach here
      // read-only offsets fall to the default branch and change nothing
      if (wrAcc) begin
         case (paddr)
            OFS_POWER_CONTROL: begin
               if (pwdata[IDLE_BIT_POS])
                  next_cur.idleBit = 1'b1;
            end
            OFS_POWER_MODE: begin
               // reserved code and direct /64 <-> /1024 hops are dropped
               if (wrDiv != DIV_RESERVED
                   && !(wrDiv != DIV_BY_4 && cur.divCode != DIV_BY_4 && wrDiv != cur.divCode))
               begin
                  next_cur.divPending = wrDiv;
                  next_cur.pendValid = 1'b1;
               end
            end
            OFS_IRQ_MASK: next_cur.mask = pwdata[IRQ_WIDTH-1:0];
            default: ;
         endcase
      end

      // run / idle / reset sequencing
      case (cur.mode)
         ST_RUN: begin
            if (instrDone && cur.pendValid) begin
               next_cur.divCode = cur.divPending;
               next_cur.pendValid = 1'b0;
               events[IRQ_RATE_POS] = 1'b1;
            end
            if (instrDone && cur.idleBit)
               next_cur.mode = ST_IDLE;
         end
         ST_IDLE: begin
            if (intRequest || wdogTimeout) begin
               next_cur.idleBit = 1'b0;
               next_cur.mode = ST_RUN;
               next_cur.serviceStart = 1'b1;
               events[IRQ_WAKE_POS] = 1'b1;
            end
         end
         ST_RESET: begin
            // held while the pin stays high, then two more machine cycles
            if (resetSync || porSync)
               next_cur.holdCnt = '0;
            else if (tick && cur.holdCnt == 2'(RESET_HOLD_MCYCLES - 1)) begin
               next_cur.mode = ST_RUN;
               next_cur.discardNext = cur.fromIdle;
               if (cur.fromIdle)
                  events[IRQ_RESET_EXIT_POS] = 1'b1;
               next_cur.fromIdle = 1'b0;
            end else if (tick)
               next_cur.holdCnt = cur.holdCnt + 2'h1;
         end
         default: next_cur.mode = ST_RUN;
      endcase

      // any reset source ends idle and returns the idle bit and divider code to defaults, dropping a pending rate
      if (resetCause) begin
         next_cur.fromIdle = (cur.mode == ST_IDLE) || cur.fromIdle;
         next_cur.mode = ST_RESET;
         next_cur.idleBit = 1'b0;
         next_cur.divCode = DIV_RESET;
         next_cur.pendValid = 1'b0;
         next_cur.holdCnt = '0;
         next_cur.pinSamples = '0;
         next_cur.wdogArmed = 1'b0;
         next_cur.wdogCnt = '0;
         // a wake in the same cycle loses to the reset: no service start
         next_cur.serviceStart = 1'b0;
         events[IRQ_WAKE_POS] = 1'b0;
      end

      // sticky status: write one clears, a new event wins
      if (wrAcc && paddr == OFS_IRQ_STATUS)
         next_cur.status = cur.status & ~pwdata[IRQ_WIDTH-1:0];
      next_cur.status = next_cur.status | events;

      // read data captured in the setup phase
      if (rdSetup) begin
         next_cur.rdata = '0;
         case (paddr)
            OFS_POWER_CONTROL: next_cur.rdata[IDLE_BIT_POS] = cur.idleBit;
            OFS_POWER_MODE: begin
               next_cur.rdata[CLOCK_DIV_HIGH_POS] = cur.divCode[1];
               next_cur.rdata[CLOCK_DIV_LOW_POS] = cur.divCode[0];
            end
            OFS_IRQ_STATUS: next_cur.rdata[IRQ_WIDTH-1:0] = cur.status;
            OFS_IRQ_MASK: next_cur.rdata[IRQ_WIDTH-1:0] = cur.mask;
            OFS_STATE: next_cur.rdata[3:0] = {cur.pendValid, cur.mode, cur.wdogArmed};
            default: next_cur.rdata = '0;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // state register
   // ----------------------------------------------------------------
   // synchronous reset to the power-up defaults, then the whole state at once
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         cur <= '{mode: ST_RESET, idleBit: 1'b0, divCode: DIV_RESET,
            divPending: DIV_RESET, pendValid: 1'b0, divCnt: '0, pinSamples: '0,
            holdCnt: '0, fromIdle: 1'b0, wdogArmed: 1'b0, wdogCnt: '0,
            status: IRQ_RESET, mask: IRQ_RESET, rdata: '0, serviceStart: 1'b0,
            discardNext: 1'b0};
      end else begin
         cur <= next_cur;
      end
   end

   // ----------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------
   // bus answers with no wait states
   // read data comes from a flop loaded in setup, so it stands through access
   assign pready = 1'b1;
   assign pslverr = psel && penable && !mapped;
   assign prdata = cur.rdata;

   // core ticks only while running; peripherals tick always
   assign coreTick = tick && (cur.mode == ST_RUN);
   assign periphTick = tick;

   // pin behaviour while idle
   assign strobeForceHigh = (cur.mode == ST_IDLE);
   assign portHold = (cur.mode == ST_IDLE);

   // reset and wake indications
   assign coreReset = (cur.mode == ST_RESET);
   assign serviceStart = cur.serviceStart;
   assign discardNext = cur.discardNext;
   assign irq = |(cur.status & cur.mask);

endmodule

`default_nettype wire

// ---- logic/power_ctrl_pkg.sv ----
/*
 * Constants for the idle and economy power controller: register map,
 * field positions, reset values, divider encodings and cycle counts.
 * Assumes a single oscillator clock that also clocks the register bus.
 */
package power_ctrl_pkg;

   // ----------------------------------------------------------------
   // register map (byte addresses)
   // ----------------------------------------------------------------
   localparam logic [7:0] OFS_POWER_CONTROL = 8'h00;
   localparam logic [7:0] OFS_POWER_MODE = 8'h04;
   localparam logic [7:0] OFS_IRQ_STATUS = 8'h08;
   localparam logic [7:0] OFS_IRQ_MASK = 8'h0C;
   localparam logic [7:0] OFS_STATE = 8'h10;

   // ----------------------------------------------------------------
   // field positions
   // ----------------------------------------------------------------
   localparam int IDLE_BIT_POS = 0;
   localparam int CLOCK_DIV_LOW_POS = 6;
   localparam int CLOCK_DIV_HIGH_POS = 7;
   localparam int IRQ_WAKE_POS = 0;
   localparam int IRQ_RESET_EXIT_POS = 1;
   localparam int IRQ_RATE_POS = 2;
   localparam int IRQ_WIDTH = 3;

   // ----------------------------------------------------------------
   // divider encodings and reset values
   // ----------------------------------------------------------------
   localparam logic [1:0] DIV_RESERVED = 2'h0;
   localparam logic [1:0] DIV_BY_4 = 2'h1;
   localparam logic [1:0] DIV_BY_64 = 2'h2;
   localparam logic [1:0] DIV_BY_1024 = 2'h3;
   localparam logic [1:0] DIV_RESET = DIV_BY_4;
   localparam logic [IRQ_WIDTH-1:0] IRQ_RESET = 3'h0;

   // ----------------------------------------------------------------
   // cycle counts, in oscillator clocks or, where named MCYCLES, machine cycles; also the clock rate in MHz and counter widths
   // ----------------------------------------------------------------
   localparam int CLK_SYS_MHZ = 200;
   localparam int CLOCKS_RATE_4 = 4;
   localparam int CLOCKS_RATE_64 = 64;
   localparam int CLOCKS_RATE_1024 = 1024;
   localparam int EXT_RESET_MIN_MCYCLES = 2;
   localparam int RESET_HOLD_MCYCLES = 2;
   localparam int WDOG_RESET_CLOCKS = 512;
   localparam int DIV_CNT_W = 10;
   localparam int WDOG_CNT_W = 10;

   // run state, gray along run -> idle -> reset
   typedef enum logic [1:0] {
      ST_RUN = 2'b00,
      ST_IDLE = 2'b01,
      ST_RESET = 2'b11
   } power_state_t;

endpackage

// ---- tb/power_ctrl_monitor.sv ----
/* port checker for power_ctrl, bound at the foot of this file
   assumes one clock and a synchronous active-high reset */
`timescale 1ns/1ps
`default_nettype none
module power_ctrl_monitor (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic intRequest,
   input wire logic wdogTimeout,
   input wire logic wdogClear,
   input wire logic wdogResetEnable,
   input wire logic powerFail,
   input wire logic coreTick,
   input wire logic periphTick,
   input wire logic strobeForceHigh,
   input wire logic portHold,
   input wire logic serviceStart,
   input wire logic coreReset,
   input wire logic discardNext
);
   logic [9:0] wdCnt;
   // ------------------------------
   // port checks
   // ------------------------------
   default clocking @(posedge clk_sys); endclocking
   default disable iff (rst);
   // age of an armed watchdog, dropped on clear or reset
   always_ff @(posedge clk_sys) begin
      if (rst || coreReset || wdogClear) begin
         wdCnt <= 10'h000;
      end else if (wdogTimeout && wdogResetEnable) begin
         wdCnt <= 10'h001;
      end else if (wdCnt != 10'h000 && wdCnt != 10'h3FF) begin
         wdCnt <= wdCnt + 10'h001;
      end
   end
   a_hold_pins: assert property (strobeForceHigh && !intRequest && !wdogTimeout
      |=> (strobeForceHigh && portHold) || coreReset) else $error("idle pins not held");
   a_idle_no_tick: assert property (strobeForceHigh |-> !coreTick)
      else $error("core ticks in idle");
   a_periph_quarter: assert property (strobeForceHigh && periphTick |=> !periphTick [*3])
      else $error("idle peripheral tick too fast");
   a_wake_service: assert property (strobeForceHigh && intRequest && !coreReset
      |=> !strobeForceHigh ##[0:1] serviceStart) else $error("no wake on interrupt");
   a_reset_exit_hold: assert property ($fell(coreReset) |-> $past(coreReset, 4))
      else $error("reset released too early");
   a_reset_ends_idle: assert property (powerFail |-> ##[1:4] (coreReset && !strobeForceHigh))
      else $error("power fail did not end idle");
   a_tick_spacing: assert property (coreTick |=> !coreTick [*3])
      else $error("core ticks closer than four clocks");
   a_wdog_reset: assert property (wdCnt == 10'h1F4 |-> ##[1:40] coreReset)
      else $error("no watchdog reset");
   c_idle_wake: cover property (strobeForceHigh && intRequest);
   c_discard: cover property (discardNext);
   c_wdog_armed: cover property (wdCnt == 10'h1F4);
endmodule
bind power_ctrl power_ctrl_monitor mon_u (.clk_sys(clk_sys), .rst(rst),
   .intRequest(intRequest), .wdogTimeout(wdogTimeout), .wdogClear(wdogClear),
   .wdogResetEnable(wdogResetEnable), .powerFail(powerFail),
   .coreTick(coreTick), .periphTick(periphTick),
   .strobeForceHigh(strobeForceHigh), .portHold(portHold), .serviceStart(serviceStart),
   .coreReset(coreReset), .discardNext(discardNext));
`default_nettype wire

// ---- tb/power_ctrl_tb.sv ----
/* self-checking bench for power_ctrl: apb master, core and pin stimulus
   assumes power_ctrl_pkg and the bound monitor are compiled first */
`timescale 1ns/1ps
`default_nettype none
module power_ctrl_tb;
   import power_ctrl_pkg::*;
   logic clk_sys, rst, psel, penable, pwrite, pready, pslverr, instrDone, intRequest;
   logic wdogTimeout, wdogClear, wdogResetEnable, resetPin, powerFail, coreTick, periphTick;
   logic strobeForceHigh, portHold, serviceStart, coreReset, discardNext, irq, err;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rd, seed;
   logic [1:0] act;
   logic [1:0] seq [6] = '{2'h2, 2'h3, 2'h1, 2'h3, 2'h0, 2'h1};
   int error_cnt = 0, check_count = 0, cyc = 0, svcN = 0, discN = 0, rstN = 0, n, m, gap;
   power_ctrl dut_u (.clk_sys(clk_sys), .rst(rst), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .instrDone(instrDone), .intRequest(intRequest),
      .wdogTimeout(wdogTimeout), .wdogClear(wdogClear), .wdogResetEnable(wdogResetEnable),
      .resetPin(resetPin), .powerFail(powerFail), .coreTick(coreTick),
      .periphTick(periphTick), .strobeForceHigh(strobeForceHigh), .portHold(portHold),
      .serviceStart(serviceStart), .coreReset(coreReset), .discardNext(discardNext),
      .irq(irq));
   // ------------------------------
   // helpers
   // ------------------------------
   function automatic logic [31:0] lfsr(input logic [31:0] x);
      return {x[30:0], 1'b0} ^ (x[31] ? 32'h04C11DB7 : 32'h00000000);
   endfunction
   function automatic logic [1:0] nextRate(input logic [1:0] cur, input logic [1:0] req);
      if (req == DIV_RESERVED || (cur != DIV_BY_4 && req != DIV_BY_4)) return cur;
      return req;
   endfunction
   function automatic int gapOf(input logic [1:0] c);
      return c == DIV_BY_64 ? CLOCKS_RATE_64 : c == DIV_BY_1024 ? CLOCKS_RATE_1024 : CLOCKS_RATE_4;
   endfunction
   task automatic finish_test();
      $display("checks %0d mismatches %0d", check_count, error_cnt);
      if (error_cnt == 0 && check_count > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      check_count++;
      if (got !== exp) begin
         error_cnt++;
         $display("FAIL %s expected %h seen %h", what, exp, got);
      end
   endtask
   // one apb transfer, held until pready is sampled high
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_sys);
      {psel, pwrite, paddr, pwdata} <= {1'b1, wr, a, d};
      @(posedge clk_sys);
      penable <= 1'b1;
      do @(posedge clk_sys); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      {psel, penable} <= 2'h0;
   endtask
   // one-clock pulse: 0 step end, 1 timeout, 2 clear, 3 interrupt
   task automatic pulse(input int w);
      @(posedge clk_sys);
      {instrDone, wdogTimeout, wdogClear, intRequest} <= 4'h8 >> w;
      @(posedge clk_sys);
      {instrDone, wdogTimeout, wdogClear, intRequest} <= 4'h0;
   endtask
   // cycles between two ticks, after aligning to one
   task automatic tickGap(input bit p, output int g);
      repeat (2) begin
         g = 0;
         do begin
            @(posedge clk_sys);
            g++;
         end while ((p ? periphTick : coreTick) !== 1'b1 && g < 3000);
      end
   endtask
   // pin held high for k clocks
   task automatic pin(input int k);
      @(posedge clk_sys);
      resetPin <= 1'b1;
      repeat (k) @(posedge clk_sys);
      resetPin <= 1'b0;
      repeat (40) @(posedge clk_sys);
   endtask
   // clock, event counters and hang guard
   initial begin
      clk_sys = 1'b0;
      forever #2.5 clk_sys = ~clk_sys;
   end
   always @(posedge clk_sys) begin
      cyc <= cyc + 1;
      svcN <= svcN + (serviceStart === 1'b1);
      discN <= discN + (discardNext === 1'b1);
      rstN <= rstN + (coreReset === 1'b1);
      if (cyc == 40000) begin
         error_cnt++;
         finish_test();
      end
   end
   // ------------------------------
   // scenarios
   // ------------------------------
   initial begin
      {rst, psel, penable, pwrite, instrDone, intRequest, wdogTimeout} = 7'h40;
      {wdogClear, wdogResetEnable, resetPin, powerFail, paddr, pwdata} = 44'h0;
      seed = 32'h0BFC47EE;
      act = DIV_RESET;
      repeat (20) @(posedge clk_sys);
      rst <= 1'b0;
      apb(0, OFS_POWER_MODE, 0);
      chk("mode reset", {24'h0, DIV_RESET, 6'h00}, rd);
      apb(0, 8'h14, 0);
      chk("unmapped", 32'h1, {rd[30:0], err});
      foreach (seq[i]) begin
         apb(1, OFS_POWER_MODE, {24'h0, seq[i], 6'h00});
         apb(0, OFS_POWER_MODE, 0);
         chk("rate pending", {24'h0, act, 6'h00}, rd);
         pulse(0);
         act = nextRate(act, seq[i]);
         apb(0, OFS_POWER_MODE, 0);
         chk("rate", {24'h0, act, 6'h00}, rd);
         tickGap(0, gap);
         chk("core gap", gapOf(act), gap);
      end
      apb(1, OFS_IRQ_MASK, 32'h0);
      chk("irq masked", 32'h0, {31'h0, irq});
      apb(1, OFS_IRQ_MASK, 32'h4);
      @(posedge clk_sys);
      chk("irq raised", 32'h1, {31'h0, irq});
      apb(1, OFS_IRQ_STATUS, 32'h4);
      apb(0, OFS_IRQ_STATUS, 0);
      chk("irq cleared", 32'h0, {rd[30:0], irq});
      repeat (6) begin
         seed = lfsr(seed);
         apb(1, OFS_IRQ_MASK, seed);
         apb(0, OFS_IRQ_MASK, 0);
         chk("mask", {29'h0, seed[2:0]}, rd);
      end
      n = rstN;
      pin(3);
      chk("short pin", n, rstN);
      apb(1, OFS_POWER_MODE, 32'h80);
      pulse(0);
      apb(1, OFS_POWER_CONTROL, 32'h1);
      repeat (3) @(posedge clk_sys);
      chk("idle early", 32'h0, {31'h0, strobeForceHigh});
      pulse(0);
      @(posedge clk_sys);
      chk("idle pins", 32'h3, {30'h0, strobeForceHigh, portHold});
      tickGap(1, gap);
      chk("idle gap", CLOCKS_RATE_4, gap);
      repeat (seed[3:0]) @(posedge clk_sys);
      n = svcN;
      pulse(3);
      repeat (4) @(posedge clk_sys);
      chk("service", n + 1, svcN);
      apb(0, OFS_POWER_CONTROL, 0);
      chk("idle bit", 32'h0, rd);
      apb(1, OFS_POWER_CONTROL, 32'h1);
      pulse(0);
      {n, m} = {rstN, discN};
      pin(200);
      chk("pin reset", 32'h1, {31'h0, rstN > n});
      chk("discard", m + 1, discN);
      apb(0, OFS_POWER_MODE, 0);
      chk("mode after", {24'h0, DIV_RESET, 6'h00}, rd);
      wdogResetEnable <= 1'b1;
      for (int i = 0; i < 3; i++) begin
         apb(1, OFS_POWER_CONTROL, 32'h1);
         pulse(0);
         n = rstN;
         powerFail <= (i == 2);
         pulse(i == 2 ? 0 : 1);
         powerFail <= 1'b0;
         repeat (3) @(posedge clk_sys);
         chk("wake", 32'h0, {31'h0, strobeForceHigh});
         if (i == 1) pulse(2);
         repeat (600) @(posedge clk_sys);
         chk("wdog reset", {31'h0, i != 1}, {31'h0, rstN > n});
      end
      finish_test();
   end
endmodule
`default_nettype wire
